// *** design/sbs_map.svh ***
// constants for the burst sram cycle logic
// Summary of operation
// - edge with deselect condition powers down, starts nothing, floats data pins.
// - sleep request high forces standby at the next rising edge, data floats at once, array retained.
// - selected edge with processor strobe, or controller strobe without write, starts read burst.
// - selected edge with controller strobe only and write active loads address and writes.
// - no strobe and step low advances burst address, reading or writing per write indication.
// - no strobe, step high, no write: re-read current burst address.
// - no strobe, step high, write active: write current address without advancing.
// - a suspended burst is a wait cycle with burst address unchanged.
// - write active when all-lane write low, or gate low with any lane low.
// - all lane enables high with all-lane write high means read.
// - lane n write enable gates exactly data byte n, lane 0 lowest.
// - inputs sampled at rising edge; output drive acts asynchronously, ignored on writes.
// - data pins float during power-up.
// - selected edge with processor strobe and sleep request low always starts a read.
// - burst order input low gives linear, high gives interleaved sequence.
// - all-lane write low writes all four byte lanes.
`ifndef SBS_MAP_SVH
`define SBS_MAP_SVH
`define SBS_ADDR_W 16
`define SBS_DATA_W 32
`define SBS_LANES 4
`define SBS_LANE_W 8
`define SBS_CNT_W 2
`define SBS_FIFO_DEPTH 16
`define SBS_CNT_RST 2'h0
`define SBS_CNT_STEP 2'h1
`endif

// *** design/sbs_pkg.sv ***
// types for the burst sram cycle logic
package sbs_pkg;
   typedef enum logic [2:0] {
      SBS_IDLE,
      SBS_READ,
      SBS_WRITE,
      SBS_SLEEP
   } sbs_state_t;
   function automatic logic sbs_write_active(input logic all_n, input logic gate_n,
                                             input logic [3:0] lanes_n);
      return (!all_n) || (!gate_n && (lanes_n != 4'hf));
   endfunction
   function automatic logic [3:0] sbs_lane_mask(input logic all_n, input logic gate_n,
                                                input logic [3:0] lanes_n);
      if (!all_n) return 4'hf;
      else if (!gate_n) return ~lanes_n;
      else return 4'h0;
   endfunction
endpackage

// *** design/sbs_fifo.sv ***
// small flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ps
module sbs_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;
   assign in_ready = cnt_q != (AW+1)'(DEPTH);
   assign out_valid = cnt_q != '0;
   assign out_data = mem_q[rd_q];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   always_ff @(posedge mclk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         if (pop) rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// *** design/sbs_burst_addr.sv ***
// burst address generator: linear or interleaved low bits
`timescale 1ns/1ps
`include "sbs_map.svh"
module sbs_burst_addr #(
   parameter int AW = `SBS_ADDR_W
) (
   input wire logic [AW-1:0] base,
   input wire logic [`SBS_CNT_W-1:0] count,
   input wire logic burst_order,
   output logic [AW-1:0] addr
);
   logic [`SBS_CNT_W-1:0] low;
   // order pin is static; changing it mid-burst scrambles the sequence
   assign low = burst_order ? (base[`SBS_CNT_W-1:0] ^ count)
                            : (base[`SBS_CNT_W-1:0] + count);
   assign addr = {base[AW-1:`SBS_CNT_W], low};
endmodule

// *** design/sbs_cycle.sv ***
// cycle decode, burst control and byte-lane array of the burst sram
`timescale 1ns/1ps
`include "sbs_map.svh"
module sbs_cycle #(
   parameter int AW = `SBS_ADDR_W,
   parameter int DW = `SBS_DATA_W,
   parameter int WORDS = 256,
   parameter int FIFO_DEPTH = `SBS_FIFO_DEPTH
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [AW-1:0] addr_in,
   input wire logic primary_select_n,
   input wire logic depth_select_low_n,
   input wire logic depth_select_high,
   input wire logic sleep_request,
   input wire logic proc_addr_strobe_n,
   input wire logic ctrl_addr_strobe_n,
   input wire logic burst_step_n,
   input wire logic all_lane_write_n,
   input wire logic lane_write_gate_n,
   input wire logic lane0_write_n,
   input wire logic lane1_write_n,
   input wire logic lane2_write_n,
   input wire logic lane3_write_n,
   input wire logic output_drive_n,
   input wire logic burst_order,
   input wire logic [DW-1:0] data_pins_in,
   output logic [DW-1:0] data_pins_out,
   output logic data_pins_oe,
   output logic read_valid,
   input wire logic read_ready,
   output logic [DW-1:0] read_data,
   output logic [AW-1:0] cur_addr,
   output logic powered_down
);
   localparam int IW = $clog2(WORDS);
   logic [3:0] lanes_n;
   logic full_sel;
   logic desel;
   logic wr_act;
   logic [3:0] lane_mask;
   logic start_read;
   logic start_write;
   logic cont;
   logic [AW-1:0] base_q;
   logic [`SBS_CNT_W-1:0] cnt_q;
   logic [AW-1:0] baddr;
   logic [AW-1:0] nxt_addr;
   logic [DW-1:0] mem_q [WORDS];
   logic [DW-1:0] q_q;
   logic rd_q;
   logic active_q;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [DW-1:0] fifo_out_data;
   sbs_pkg::sbs_state_t st_q;

   assign lanes_n = {lane3_write_n, lane2_write_n, lane1_write_n, lane0_write_n};
   assign full_sel = !primary_select_n && !depth_select_low_n && depth_select_high;
   // deselect needs a strobe; with primary select high only the controller strobe counts
   assign desel = (primary_select_n && !ctrl_addr_strobe_n) ||
                  (!primary_select_n && (depth_select_low_n || !depth_select_high) &&
                   (!proc_addr_strobe_n || !ctrl_addr_strobe_n));
   assign wr_act = sbs_pkg::sbs_write_active(all_lane_write_n, lane_write_gate_n,
                                             lanes_n);
   assign lane_mask = sbs_pkg::sbs_lane_mask(all_lane_write_n, lane_write_gate_n,
                                             lanes_n);
   assign start_read = full_sel && (!proc_addr_strobe_n ||
                       (!ctrl_addr_strobe_n && !wr_act));
   assign start_write = full_sel && proc_addr_strobe_n && !ctrl_addr_strobe_n &&
                        wr_act;
   // processor strobe is ignored while primary select is high
   assign cont = ctrl_addr_strobe_n && (proc_addr_strobe_n || primary_select_n) &&
                 active_q;

   sbs_burst_addr #(.AW(AW)) u_addr (
      .base(base_q),
      .count(cnt_q),
      .burst_order(burst_order),
      .addr(baddr)
   );

   always_comb begin
      nxt_addr = baddr;
      if (start_read || start_write) begin
         nxt_addr = addr_in;
      end else if (cont && !burst_step_n) begin
         nxt_addr = {base_q[AW-1:`SBS_CNT_W], base_q[`SBS_CNT_W-1:0] ^ (cnt_q + `SBS_CNT_STEP)};
         if (!burst_order) begin
            nxt_addr = {base_q[AW-1:`SBS_CNT_W],
                        base_q[`SBS_CNT_W-1:0] + cnt_q + `SBS_CNT_STEP};
         end
      end
   end

   // address register and burst counter
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         base_q <= '0;
         cnt_q <= `SBS_CNT_RST;
      end else if (!sleep_request) begin
         if (start_read || start_write) begin
            base_q <= addr_in;
            cnt_q <= `SBS_CNT_RST;
         end else if (cont && !burst_step_n) begin
            cnt_q <= cnt_q + `SBS_CNT_STEP;
         end
         // step high keeps the counter: suspended burst is a wait cycle
      end
   end

   // state: whether a burst is open, and what the last edge did
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= sbs_pkg::SBS_IDLE;
         active_q <= 1'b0;
      end else if (sleep_request) begin
         st_q <= sbs_pkg::SBS_SLEEP;
      end else if (desel) begin
         st_q <= sbs_pkg::SBS_IDLE;
         active_q <= 1'b0;
      end else if (start_read) begin
         st_q <= sbs_pkg::SBS_READ;
         active_q <= 1'b1;
      end else if (start_write) begin
         st_q <= sbs_pkg::SBS_WRITE;
         active_q <= 1'b1;
      end else if (cont) begin
         st_q <= wr_act ? sbs_pkg::SBS_WRITE : sbs_pkg::SBS_READ;
      end else begin
         case (st_q)
            sbs_pkg::SBS_SLEEP: st_q <= sbs_pkg::SBS_IDLE;
            default: st_q <= st_q;
         endcase
      end
   end

   // array write, byte lanes; a strobe-started processor cycle never writes
   always_ff @(posedge mclk) begin
      if (!sleep_request && (start_write || (cont && wr_act && !start_read))) begin
         for (int i = 0; i < `SBS_LANES; i++) begin
            if (lane_mask[i]) begin
               mem_q[nxt_addr[IW-1:0]][i*`SBS_LANE_W +: `SBS_LANE_W] <=
                  data_pins_in[i*`SBS_LANE_W +: `SBS_LANE_W];
            end
         end
      end
   end

   // read register: holds data of the current read edge
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         q_q <= '0;
         rd_q <= 1'b0;
      end else if (sleep_request || desel) begin
         rd_q <= 1'b0;
      end else if (start_read || (cont && !wr_act)) begin
         q_q <= mem_q[nxt_addr[IW-1:0]];
         rd_q <= 1'b1;
      end else begin
         rd_q <= 1'b0;
      end
   end

   // pin drive: floats in reset, sleep, writes or output drive high.
   // output drive is asynchronous, so this enable is combinational by design
   assign data_pins_oe = rd_q && !output_drive_n && !sleep_request;
   assign data_pins_out = q_q;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cur_addr <= '0;
         powered_down <= 1'b1;
      end else begin
         cur_addr <= nxt_addr;
         powered_down <= sleep_request || desel || !(active_q || start_read || start_write);
      end
   end

   // read stream to the user side; full fifo only drops words, the pins are unaffected
   sbs_fifo #(.WIDTH(DW), .DEPTH(FIFO_DEPTH)) u_fifo (
      .mclk(mclk),
      .rst_b(rst_b),
      .in_valid(rd_q),
      .in_ready(fifo_in_ready),
      .in_data(q_q),
      .out_valid(fifo_out_valid),
      .out_ready(!read_valid || read_ready),
      .out_data(fifo_out_data)
   );

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         read_valid <= 1'b0;
         read_data <= '0;
      end else if (!read_valid || read_ready) begin
         read_valid <= fifo_out_valid;
         read_data <= fifo_out_data;
      end
   end

   a_desel_float: assert property (@(posedge mclk) disable iff (!rst_b)
      (desel && !sleep_request)
      |=> !data_pins_oe)
      else $error("pins driven after deselect");

   a_desel_close: assert property (@(posedge mclk) disable iff (!rst_b)
      (desel && !sleep_request)
      |=> !active_q && powered_down)
      else $error("deselect left burst open");

   a_sleep_float: assert property (@(posedge mclk) disable iff (!rst_b)
      sleep_request
      |-> !data_pins_oe)
      else $error("pins driven in sleep");

   a_sleep_hold: assert property (@(posedge mclk) disable iff (!rst_b)
      sleep_request
      |=> $stable(base_q) && $stable(cnt_q) && !rd_q && powered_down)
      else $error("sleep edge started a cycle");

   a_read_start: assert property (@(posedge mclk) disable iff (!rst_b)
      (start_read && !sleep_request)
      |=> rd_q && base_q == $past(addr_in))
      else $error("read start missed");

   a_ctrl_read: assert property (@(posedge mclk) disable iff (!rst_b)
      (full_sel && proc_addr_strobe_n && !ctrl_addr_strobe_n && !wr_act && !sleep_request)
      |=> rd_q)
      else $error("controller strobe did not read");

   a_wr_noread: assert property (@(posedge mclk) disable iff (!rst_b)
      (start_write && !sleep_request)
      |=> !rd_q && !data_pins_oe)
      else $error("write drove pins");

   a_wr_load: assert property (@(posedge mclk) disable iff (!rst_b)
      (start_write && !sleep_request)
      |=> base_q == $past(addr_in) && cnt_q == `SBS_CNT_RST)
      else $error("write start did not load address");

   a_step_count: assert property (@(posedge mclk) disable iff (!rst_b)
      (cont && !burst_step_n && !desel && !sleep_request)
      |=> cnt_q == $past(cnt_q) + `SBS_CNT_STEP)
      else $error("burst did not advance");

   a_step_upper: assert property (@(posedge mclk) disable iff (!rst_b)
      (cont && !burst_step_n && !sleep_request)
      |=> cur_addr[AW-1:`SBS_CNT_W] == base_q[AW-1:`SBS_CNT_W])
      else $error("burst step left its block");

   a_cont_read: assert property (@(posedge mclk) disable iff (!rst_b)
      (cont && !wr_act && !sleep_request)
      |=> rd_q)
      else $error("continue without write did not read");

   a_cont_write: assert property (@(posedge mclk) disable iff (!rst_b)
      (cont && wr_act && !sleep_request)
      |=> !rd_q && !data_pins_oe)
      else $error("continue with write drove a read");

   a_suspend_hold: assert property (@(posedge mclk) disable iff (!rst_b)
      (cont && burst_step_n && !desel && !sleep_request)
      |=> $stable(cnt_q) && $stable(base_q))
      else $error("suspend moved address");

   a_suspend_addr: assert property (@(posedge mclk) disable iff (!rst_b)
      (cont && burst_step_n && !sleep_request)
      |=> cur_addr == baddr)
      else $error("suspend used another address");

   a_proc_read: assert property (@(posedge mclk) disable iff (!rst_b)
      (full_sel && !proc_addr_strobe_n && !sleep_request)
      |=> rd_q)
      else $error("processor strobe did not read");

   a_wr_decode: assert property (@(posedge mclk) disable iff (!rst_b)
      (!all_lane_write_n |-> lane_mask == 4'hf)
      and (lanes_n == 4'hf && all_lane_write_n |-> !wr_act))
      else $error("write decode wrong");

   a_lane_mask: assert property (@(posedge mclk) disable iff (!rst_b)
      (all_lane_write_n && !lane_write_gate_n)
      |-> lane_mask == ~lanes_n)
      else $error("lane mask wrong");

   a_oe_gate: assert property (@(posedge mclk) disable iff (!rst_b)
      output_drive_n
      |-> !data_pins_oe)
      else $error("pins driven with output drive high");

   a_power_up: assert property (@(posedge mclk)
      $rose(rst_b)
      |-> !data_pins_oe && powered_down)
      else $error("pins driven at power-up");

   c_burst_four: cover property (@(posedge mclk) disable iff (!rst_b)
      start_read ##1 (cont && !burst_step_n)[*3]);
   c_write_start: cover property (@(posedge mclk) disable iff (!rst_b)
      start_write);
   c_sleep: cover property (@(posedge mclk) disable iff (!rst_b)
      sleep_request ##1 !sleep_request);
   c_wait_write: cover property (@(posedge mclk) disable iff (!rst_b)
      (st_q == sbs_pkg::SBS_READ) ##1 (st_q == sbs_pkg::SBS_WRITE));
   c_fifo_full: cover property (@(posedge mclk) disable iff (!rst_b)
      rd_q && !fifo_in_ready);
endmodule

// *** tb/sbs_ctl_model.sv ***
// controller model driving burst bus cycles into the sram cycle logic
`timescale 1ns/1ps
module sbs_ctl_model (
   input wire logic mclk,
   input wire logic [2:0] op,
   input wire logic all_req_n,
   input wire logic gate_req_n,
   input wire logic [3:0] ln_n,
   input wire logic [15:0] a,
   input wire logic [31:0] d,
   input wire logic oe_req_n,
   output logic [15:0] addr_in,
   output logic primary_select_n,
   output logic depth_select_low_n,
   output logic depth_select_high,
   output logic proc_addr_strobe_n,
   output logic ctrl_addr_strobe_n,
   output logic burst_step_n,
   output logic all_lane_write_n,
   output logic lane_write_gate_n,
   output logic [3:0] lane_n,
   output logic output_drive_n,
   output logic [31:0] data_pins_in
);
   // op: 0 proc start, 1 ctrl start, 2 step, 3 hold, 4..6 three deselect forms
   logic wr;
   logic [31:0] last_q = 32'h0;
   assign wr = !all_req_n || (!gate_req_n && ln_n != 4'hf);
   assign addr_in = a;
   assign all_lane_write_n = all_req_n;
   assign lane_write_gate_n = gate_req_n;
   assign lane_n = ln_n;
   // step comes with primary select high and proc strobe low, which must be ignored
   assign primary_select_n = (op == 3'h2) || (op == 3'h4);
   assign proc_addr_strobe_n = !(op == 3'h0 || op == 3'h2 || op == 3'h5);
   assign ctrl_addr_strobe_n = !(op == 3'h1 || op == 3'h4 || op == 3'h6);
   assign burst_step_n = op != 3'h2;
   assign depth_select_low_n = op == 3'h5;
   assign depth_select_high = op != 3'h6;
   // read drive dropped in the same cycles as, and through, any write data
   assign output_drive_n = wr || oe_req_n;
   // released lines flip every cycle so a stale copy can never pass
   assign data_pins_in = wr ? d : ~last_q;
   always @(posedge mclk) last_q <= data_pins_in;
endmodule

// *** tb/tb.sv ***
// self-checking bench for the burst sram cycle logic with a behavioural model
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
$display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb;
   logic mclk = 0, rst_b = 0, read_ready = 1, burst_order = 0, sleep_request = 0;
   logic all_req_n = 1, gate_req_n = 0, oe_req_n = 0, primary_select_n, depth_select_low_n;
   logic depth_select_high, proc_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n;
   logic all_lane_write_n, lane_write_gate_n, output_drive_n, data_pins_oe, read_valid;
   logic powered_down;
   logic [2:0] op = 3'h3;
   logic [3:0] ln_n = 4'hf, lane_n;
   logic [13:0] grp = 14'h0;
   logic [15:0] a = 16'h0, addr_in, cur_addr, p_ea;
   logic [31:0] d = 32'h0, data_pins_in, data_pins_out, read_data, p_m, ew;
   logic [31:0] mem [256];
   logic [31:0] expq [$];
   int n_errors = 0, n_compared = 0, n_got = 0, seed = 29, base = 0, cnt = 0;
   bit open = 0, p_rd = 0, p_wr = 0;
   always #10 mclk = ~mclk;
   sbs_ctl_model ctl (.mclk, .op, .all_req_n, .gate_req_n, .ln_n, .a, .d, .oe_req_n, .addr_in,
      .primary_select_n, .depth_select_low_n, .depth_select_high, .proc_addr_strobe_n,
      .ctrl_addr_strobe_n, .burst_step_n, .all_lane_write_n, .lane_write_gate_n, .lane_n,
      .output_drive_n, .data_pins_in);
   sbs_cycle DUT (.mclk, .rst_b, .addr_in, .primary_select_n, .depth_select_low_n,
      .depth_select_high, .sleep_request, .proc_addr_strobe_n, .ctrl_addr_strobe_n,
      .burst_step_n, .all_lane_write_n, .lane_write_gate_n, .lane0_write_n(lane_n[0]),
      .lane1_write_n(lane_n[1]), .lane2_write_n(lane_n[2]), .lane3_write_n(lane_n[3]),
      .output_drive_n, .burst_order, .data_pins_in, .data_pins_out, .data_pins_oe,
      .read_valid, .read_ready, .read_data, .cur_addr, .powered_down);
   // every read word must come out of the stream in issue order
   always @(posedge mclk)
      if (read_valid === 1'b1 && read_ready) begin
         n_got++;
         ew = 32'hx;
         if (expq.size() > 0) ew = expq.pop_front();
         `CHK("read_data", ew, read_data)
      end
   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // one bus cycle; results of the previous cycle are checked mid-cycle
   task automatic cyc(input logic [2:0] o, input logic [3:0] l, input logic g);
      logic [15:0] ea;
      logic [15:0] r;
      logic [3:0] mk;
      logic wa;
      r = 16'($random(seed));
      op <= o;
      ln_n <= l;
      all_req_n <= g;
      oe_req_n <= 1'($random(seed));
      a <= {(o < 3'h2) ? grp : r[15:2], r[1:0]};
      d <= $random(seed);
      @(negedge mclk);
      if (p_wr || p_rd) `CHK("cur_addr", p_ea, cur_addr)
      if (p_rd) `CHK("data_pins_out", p_m, data_pins_out)
      `CHK("powered_down", !(p_rd || p_wr), powered_down)
      `CHK("data_pins_oe", p_rd && !output_drive_n && !sleep_request, data_pins_oe)
      wa = !g || (!gate_req_n && l != 4'hf);
      mk = !g ? 4'hf : (gate_req_n ? 4'h0 : ~l);
      p_rd = 0;
      p_wr = 0;
      if (!sleep_request) begin
         if (o > 3'h3) open = 0;
         if (o < 3'h2) begin
            base = a;
            cnt = 0;
            open = 1;
         end else if (o == 3'h2 && open) cnt = (cnt + 1) % 4;
         ea = {base[15:2], burst_order ? base[1:0] ^ cnt[1:0] : base[1:0] + cnt[1:0]};
         p_wr = open && o != 3'h0 && o < 3'h4 && wa;
         p_rd = open && o < 3'h4 && !p_wr;
         for (int i = 0; i < 4; i++)
            if (p_wr && mk[i]) mem[ea[7:0]][8*i +: 8] = d[8*i +: 8];
         p_m = mem[ea[7:0]];
         if (p_rd) expq.push_back(p_m);
      end
      p_ea = ea;
      @(posedge mclk);
   endtask
   // bounded wait for the read stream to go idle
   task automatic drain();
      int k;
      repeat (5) @(posedge mclk);
      for (k = 0; k < 100 && read_valid === 1'b1; k++) @(posedge mclk);
      if (k == 100) begin
         n_errors++;
         $display("[FAIL] read_valid expected 0 seen 1");
         finish_test();
      end
   endtask
   initial begin
      repeat (10) @(posedge mclk);
      `CHK("reset data_pins_oe", 1'b0, data_pins_oe)
      `CHK("reset powered_down", 1'b1, powered_down)
      rst_b <= 1;
      @(posedge mclk);
      for (int t = 0; t < 2; t++) begin
         burst_order <= t[0];
         grp = 14'($random(seed));
         cyc(3'h1, 4'hf, 0);
         repeat (3) cyc(3'h2, 4'h0, 1);
         cyc(3'h3, 4'($random(seed)), 1);
         cyc(3'h0, 4'($random(seed)), 1'($random(seed)));
         repeat (4) cyc(3'h2, 4'hf, 1);
         cyc(3'h3, 4'hf, 1);
         cyc(3'h1, 4'hf, 1);
         gate_req_n <= 1;
         cyc(3'h1, 4'h0, 1);
         gate_req_n <= 0;
         cyc(3'h0, 4'hf, 1);
         cyc(3'h3, 4'($random(seed)) & 4'h7, 1);
         cyc(3'h3, 4'hf, 1);
         for (int k = 4; k < 7; k++) cyc(k[2:0], 4'hf, 1);
         cyc(3'h2, 4'hf, 1);
         $display("test burst order %0d done", t);
      end
      cyc(3'h0, 4'hf, 1);
      sleep_request <= 1;
      cyc(3'h1, 4'h0, 0);
      cyc(3'h0, 4'hf, 1);
      sleep_request <= 0;
      cyc(3'h0, 4'hf, 1);
      cyc(3'h4, 4'hf, 1);
      drain();
      `CHK("pending reads", 0, expq.size())
      $display("test sleep done");
      // far side stalls: the buffer fills, refuses, then drains in order
      read_ready <= 0;
      n_got = 0;
      cyc(3'h0, 4'hf, 1);
      repeat (19) cyc(3'h2, 4'hf, 1);
      cyc(3'h4, 4'hf, 1);
      read_ready <= 1;
      drain();
      `CHK("buffered words at least 16", 1'b1, n_got >= 16)
      expq.delete();
      $display("test stream stall done");
      finish_test();
   end
endmodule
